// ==== design/dmr_data_memory.sv ====
// Contract
// R01 - data addresses are one byte; 128 bytes of ram hold data and stack
// R02 - software loads the stack pointer within 00h..7Fh before using the stack
// R03 - peripheral control and status registers sit at C0h..FFh
// R04 - unimplemented control addresses may read junk and ignore writes
// R05 - write-only registers are written by whole-byte stores only
// R06 - ECh reads the interval timer, writes the clock divider control
// R07 - D1h reads count or capture by mode; timer-mode write loads compare
// R08 - D3h write loads timer1 compare, or pwm period in pwm mode
// R09 - D4h reads count, capture or duty by mode; pwm-mode write loads duty
// R10 - control registers take their listed values at reset
// R11 - call and interrupt acceptance push the return address on the stack
// R12 - subroutine return restores pc; interrupt return restores pc and flags
// R13 - stack pointer decrements after a save, increments before a restore
// R14 - immediate mode uses the second instruction byte as data
// R15 - absolute mode forms a 16-bit address, low byte then high byte
// R16 - auto-increment mode uses X as direct-page address then adds one
// R17 - no-offset indexed mode uses X as direct-page address
// R18 - register mode selects accumulator, X, Y, carry or status word
// R19 - decode ram at 00h..7Fh, registers at C0h..FFh, 80h..BFh unused
`timescale 1ns/10ps

module dmr_data_memory
  import dmr_pkg::*;
#(
  parameter int RAM_DEPTH = 128
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire dmr_req_t    req,
  input  wire dmr_stk_t    stk,
  input  wire dmr_core_t   core,
  input  wire dmr_sts_t    sts,
  input  wire logic [7:0]  pin_a,
  input  wire logic [7:0]  pin_b,
  input  wire logic [7:0]  pin_c,
  output logic             ack_r,
  output logic [7:0]       rdata_r,
  output logic [15:0]      eff_addr_r,
  output logic             busy_r,
  output logic             stk_done_r,
  output logic [15:0]      pc_restore_r,
  output logic [7:0]       psw_restore_r,
  output logic [7:0]       x_r,
  output logic [7:0]       sp_r,
  output dmr_ctrl_t        ctrl_r
);

`include "dmr_params.svh"

  typedef enum logic {ST_IDLE, ST_STACK} dmr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [7:0] pin_a_m, pin_b_m, pin_c_m;
  logic [7:0] pin_a_s, pin_b_s, pin_c_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_a_m <= 8'h00;
      pin_b_m <= 8'h00;
      pin_c_m <= 8'h00;
      pin_a_s <= 8'h00;
      pin_b_s <= 8'h00;
      pin_c_s <= 8'h00;
    end else begin
      pin_a_m <= pin_a;
      pin_b_m <= pin_b;
      pin_c_m <= pin_c;
      pin_a_s <= pin_a_m;
      pin_b_s <= pin_b_m;
      pin_c_s <= pin_c_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request acceptance and effective address
  logic        take;
  logic        take_stk;
  logic [15:0] addr;
  logic        is_mem;
  logic        in_ram;
  logic        in_ctrl;
  logic        mem_wr;
  logic [7:0]  a8;

  // the stack sequencer owns the ram port while busy; a request then is dropped
  assign take_stk = stk.vld & ~busy_r;
  assign take     = req.vld & ~busy_r & ~stk.vld;

  always_comb begin
    addr   = 16'h0000;
    is_mem = 1'b0;
    case (req.mode)
      DMR_AM_DIRECT: begin
        addr   = {8'h00, req.op1};
        is_mem = 1'b1;
      end
      DMR_AM_ABSOLUTE: begin
        addr   = {req.op2, req.op1}; // R15
        is_mem = 1'b1;
      end
      DMR_AM_X_PLAIN,
      DMR_AM_X_AUTOINC: begin
        addr   = {8'h00, x_r}; // R16 R17
        is_mem = 1'b1;
      end
      default: begin
        addr   = 16'h0000;
        is_mem = 1'b0;
      end
    endcase
  end

  // only page zero is data memory; far absolute addresses fall outside it
  assign a8      = addr[7:0];
  assign in_ram  = is_mem & (addr[15:8] == 8'h00) & (a8 <= `DMR_RAM_TOP); // R01 R19
  assign in_ctrl = is_mem & (addr[15:8] == 8'h00) & (a8 >= `DMR_CTRL_BASE); // R03 R19
  assign mem_wr  = take & req.wr;

  ////////////////////////////////////////////////////////////////////////////
  // stack sequencer
  dmr_state_t  state_r;
  dmr_skind_t  kind_r;
  logic [1:0]  step_r;
  logic [1:0]  last_step;
  logic        is_push;
  logic [15:0] pc_hold_r;
  logic [7:0]  psw_hold_r;
  logic [7:0]  push_byte;
  logic [7:0]  sp_up;
  logic [7:0]  ram_q_pop;

  assign is_push   = (kind_r == DMR_SK_CALL) | (kind_r == DMR_SK_INT);
  assign last_step = ((kind_r == DMR_SK_INT) | (kind_r == DMR_SK_ISR_EXIT_INSTRUCTION)) ? 2'd2 : 2'd1;
  assign sp_up     = sp_r + 8'h01;

  // push order pc high, pc low, flags; pops run in reverse
  always_comb begin
    case (step_r)
      2'd0:    push_byte = pc_hold_r[15:8];
      2'd1:    push_byte = pc_hold_r[7:0];
      default: push_byte = psw_hold_r;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= ST_IDLE;
      kind_r     <= DMR_SK_CALL;
      step_r     <= 2'd0;
      pc_hold_r  <= 16'h0000;
      psw_hold_r <= 8'h00;
      busy_r     <= 1'b0;
      stk_done_r <= 1'b0;
    end else begin
      stk_done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take_stk) begin // R11 R12
            state_r    <= ST_STACK;
            kind_r     <= stk.kind;
            step_r     <= 2'd0;
            pc_hold_r  <= stk.pc;
            psw_hold_r <= stk.processor_status_word;
            busy_r     <= 1'b1;
          end
        end
        ST_STACK: begin
          if (step_r == last_step) begin
            state_r    <= ST_IDLE;
            busy_r     <= 1'b0;
            stk_done_r <= 1'b1;
          end else begin
            step_r <= step_r + 2'd1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // restored values; pc only for a plain return, flags too for isr exit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_restore_r  <= 16'h0000;
      psw_restore_r <= 8'h00;
    end else if (state_r == ST_STACK && !is_push) begin // R12
      if (kind_r == DMR_SK_ISR_EXIT_INSTRUCTION && step_r == 2'd0) begin
        psw_restore_r <= ram_q_pop;
      end else if (step_r == last_step) begin
        pc_restore_r[15:8] <= ram_q_pop;
      end else begin
        pc_restore_r[7:0] <= ram_q_pop;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // index and stack pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      x_r <= 8'h00;
    end else if (take && req.mode == DMR_AM_LOAD_X) begin
      x_r <= req.wdata;
    end else if (take && req.mode == DMR_AM_X_AUTOINC) begin
      x_r <= x_r + 8'h01; // R16
    end
  end

  // no reset value is promised to software; zero keeps simulation defined
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_r <= 8'h00;
    end else if (state_r == ST_STACK) begin
      sp_r <= is_push ? sp_r - 8'h01 : sp_up; // R13
    end else if (take && req.mode == DMR_AM_LOAD_SP) begin
      sp_r <= req.wdata; // R02
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user ram, shared with the stack
  logic [7:0] ram [RAM_DEPTH];
  logic [6:0] ram_wa;
  logic [7:0] ram_wd;
  logic       ram_we;

  // stack lives at sp itself; no guard against stack overrunning user data
  assign ram_q_pop = ram[sp_up[6:0]]; // R13

  always_comb begin
    if (state_r == ST_STACK && is_push) begin
      ram_we = 1'b1;
      ram_wa = sp_r[6:0]; // R11 R13
      ram_wd = push_byte;
    end else begin
      ram_we = mem_wr & in_ram;
      ram_wa = a8[6:0];
      ram_wd = req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd; // R01
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register writes
  logic       cw;
  logic       cap0, cap1, pwme;

  assign cw   = mem_wr & in_ctrl;
  assign cap0 = ctrl_r.timer0_mode[`DMR_BIT_CAP0];
  assign cap1 = ctrl_r.timer1_mode[`DMR_BIT_CAP1];
  assign pwme = ctrl_r.timer1_mode[`DMR_BIT_PWME];

  // unlisted offsets in the window fall through and are ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin // R10
      ctrl_r.port_a_data           <= `DMR_RST_ZERO;
      ctrl_r.port_a_direction      <= `DMR_RST_ZERO;
      ctrl_r.port_b_data           <= `DMR_RST_ZERO;
      ctrl_r.port_b_direction      <= `DMR_RST_ZERO;
      ctrl_r.port_c_data           <= `DMR_RST_ZERO;
      ctrl_r.port_c_direction      <= `DMR_RST_ZERO;
      ctrl_r.port_a_alt_select     <= `DMR_RST_ZERO;
      ctrl_r.port_b_alt_select     <= `DMR_RST_ZERO;
      ctrl_r.pullup_select         <= `DMR_RST_ZERO;
      ctrl_r.timer0_mode           <= `DMR_RST_ZERO;
      ctrl_r.timer0_compare        <= `DMR_RST_ONES;
      ctrl_r.timer1_mode           <= `DMR_RST_ZERO;
      ctrl_r.timer1_compare        <= `DMR_RST_ONES;
      ctrl_r.pwm_period            <= `DMR_RST_ONES;
      ctrl_r.pwm_duty              <= `DMR_RST_ZERO;
      ctrl_r.pwm_high_bits         <= `DMR_RST_ZERO;
      ctrl_r.buzzer_divider        <= `DMR_RST_ONES;
      ctrl_r.int_enable_high       <= `DMR_RST_ZERO;
      ctrl_r.int_enable_low        <= `DMR_RST_ZERO;
      ctrl_r.ext_int_edge_select   <= `DMR_RST_ZERO;
      ctrl_r.adc_mode_control      <= `DMR_RST_ADC_MODE;
      ctrl_r.clock_divider_control <= `DMR_RST_CLK_DIV;
      ctrl_r.watchdog_counter      <= `DMR_RST_WATCHDOG;
      ctrl_r.power_fail_control    <= `DMR_RST_POWER_FAIL;
    end else if (cw) begin // R03 R04 R05
      case (a8)
        `DMR_OFS_PORT_A_DATA: ctrl_r.port_a_data         <= req.wdata;
        `DMR_OFS_PORT_A_DIR:  ctrl_r.port_a_direction    <= req.wdata;
        `DMR_OFS_PORT_B_DATA: ctrl_r.port_b_data         <= req.wdata;
        `DMR_OFS_PORT_B_DIR:  ctrl_r.port_b_direction    <= req.wdata;
        `DMR_OFS_PORT_C_DATA: ctrl_r.port_c_data         <= req.wdata;
        `DMR_OFS_PORT_C_DIR:  ctrl_r.port_c_direction    <= req.wdata;
        `DMR_OFS_PORT_A_ALT:  ctrl_r.port_a_alt_select   <= req.wdata;
        `DMR_OFS_PORT_B_ALT:  ctrl_r.port_b_alt_select   <= req.wdata;
        `DMR_OFS_PULLUP:      ctrl_r.pullup_select       <= req.wdata;
        `DMR_OFS_TIMER0_MODE: ctrl_r.timer0_mode         <= req.wdata;
        `DMR_OFS_TIMER0_DATA: begin
          if (!cap0) begin
            ctrl_r.timer0_compare <= req.wdata; // R07
          end
        end
        `DMR_OFS_TIMER1_MODE: ctrl_r.timer1_mode         <= req.wdata;
        `DMR_OFS_TIMER1_CMP: begin
          if (pwme) begin
            ctrl_r.pwm_period <= req.wdata; // R08
          end else begin
            ctrl_r.timer1_compare <= req.wdata; // R08
          end
        end
        `DMR_OFS_TIMER1_DATA: begin
          if (pwme) begin
            ctrl_r.pwm_duty <= req.wdata; // R09
          end
        end
        `DMR_OFS_PWM_HIGH:    ctrl_r.pwm_high_bits       <= req.wdata;
        `DMR_OFS_BUZZER:      ctrl_r.buzzer_divider      <= req.wdata;
        `DMR_OFS_INT_EN_HIGH: ctrl_r.int_enable_high     <= req.wdata;
        `DMR_OFS_INT_EN_LOW:  ctrl_r.int_enable_low      <= req.wdata;
        `DMR_OFS_EDGE_SEL:    ctrl_r.ext_int_edge_select <= req.wdata;
        `DMR_OFS_ADC_MODE:    ctrl_r.adc_mode_control    <= req.wdata;
        `DMR_OFS_INTERVAL:    ctrl_r.clock_divider_control <= req.wdata; // R06
        `DMR_OFS_WATCHDOG:    ctrl_r.watchdog_counter    <= req.wdata;
        `DMR_OFS_POWER_FAIL:  ctrl_r.power_fail_control  <= req.wdata;
        default: begin
        end
      endcase
    end
  end

  // request flags: a hardware set in the same cycle beats a software write
  logic [7:0] irq_h_nxt, irq_l_nxt;

  always_comb begin
    irq_h_nxt = ctrl_r.int_request_high;
    irq_l_nxt = ctrl_r.int_request_low;
    if (cw && a8 == `DMR_OFS_INT_REQ_HIGH) begin
      irq_h_nxt = req.wdata;
    end
    if (cw && a8 == `DMR_OFS_INT_REQ_LOW) begin
      irq_l_nxt = req.wdata;
    end
    irq_h_nxt = (irq_h_nxt | sts.irq_set_high) & `DMR_MSK_INT_HIGH;
    irq_l_nxt = (irq_l_nxt | sts.irq_set_low) & `DMR_MSK_INT_LOW;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r.int_request_high <= `DMR_RST_ZERO; // R10
      ctrl_r.int_request_low  <= `DMR_RST_ZERO;
    end else begin
      ctrl_r.int_request_high <= irq_h_nxt;
      ctrl_r.int_request_low  <= irq_l_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [7:0] ctrl_q;
  logic [7:0] reg_q;
  logic [7:0] rd_nxt;

  // write-only and unused offsets read as zero rather than junk
  always_comb begin
    case (a8)
      `DMR_OFS_PORT_A_DATA:  ctrl_q = pin_a_s;
      `DMR_OFS_PORT_B_DATA:  ctrl_q = pin_b_s & `DMR_MSK_PORT_B;
      `DMR_OFS_PORT_C_DATA:  ctrl_q = pin_c_s & `DMR_MSK_PORT_C;
      `DMR_OFS_TIMER0_MODE:  ctrl_q = ctrl_r.timer0_mode & `DMR_MSK_TIMER0_MODE;
      `DMR_OFS_TIMER0_DATA:  ctrl_q = cap0 ? sts.capture0_value : sts.timer0_count; // R07
      `DMR_OFS_TIMER1_MODE:  ctrl_q = ctrl_r.timer1_mode;
      `DMR_OFS_TIMER1_DATA:  ctrl_q = pwme ? ctrl_r.pwm_duty :
                                      cap1 ? sts.capture1_value : sts.timer1_count; // R09
      `DMR_OFS_INT_EN_HIGH:  ctrl_q = ctrl_r.int_enable_high & `DMR_MSK_INT_HIGH;
      `DMR_OFS_INT_EN_LOW:   ctrl_q = ctrl_r.int_enable_low & `DMR_MSK_INT_LOW;
      `DMR_OFS_INT_REQ_HIGH: ctrl_q = ctrl_r.int_request_high;
      `DMR_OFS_INT_REQ_LOW:  ctrl_q = ctrl_r.int_request_low;
      `DMR_OFS_EDGE_SEL:     ctrl_q = ctrl_r.ext_int_edge_select & `DMR_MSK_EDGE_SEL;
      `DMR_OFS_ADC_MODE:     ctrl_q = ctrl_r.adc_mode_control & `DMR_MSK_ADC_MODE;
      `DMR_OFS_ADC_RESULT:   ctrl_q = sts.adc_result;
      `DMR_OFS_INTERVAL:     ctrl_q = sts.interval_timer_count; // R06
      `DMR_OFS_WATCHDOG:     ctrl_q = ctrl_r.watchdog_counter & `DMR_MSK_WATCHDOG;
      `DMR_OFS_POWER_FAIL:   ctrl_q = ctrl_r.power_fail_control & `DMR_MSK_POWER_FAIL;
      default:               ctrl_q = 8'h00; // R04
    endcase
  end

  always_comb begin
    case (req.rsel)
      DMR_RS_ACC:   reg_q = core.acc; // R18
      DMR_RS_X:     reg_q = x_r;
      DMR_RS_Y:     reg_q = core.y;
      DMR_RS_CARRY: reg_q = {7'h00, core.carry};
      DMR_RS_PSW:   reg_q = core.processor_status_word;
      default:      reg_q = 8'h00;
    endcase
  end

  always_comb begin
    if (req.mode == DMR_AM_REGISTER) begin
      rd_nxt = reg_q;
    end else if (req.mode == DMR_AM_IMMEDIATE) begin
      rd_nxt = req.op1; // R14
    end else if (in_ram) begin
      rd_nxt = ram[a8[6:0]];
    end else if (in_ctrl) begin
      rd_nxt = ctrl_q;
    end else begin
      rd_nxt = 8'h00; // R19
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_r      <= 1'b0;
      rdata_r    <= 8'h00;
      eff_addr_r <= 16'h0000;
    end else begin
      ack_r <= take;
      if (take) begin
        rdata_r    <= req.wr ? 8'h00 : rd_nxt;
        eff_addr_r <= addr;
      end
    end
  end

endmodule

// ==== pkg/dmr_params.svh ====
`ifndef DMR_PARAMS_SVH
`define DMR_PARAMS_SVH

// address space split
`define DMR_RAM_TOP          8'h7f
`define DMR_CTRL_BASE        8'hc0

// control register offsets
`define DMR_OFS_PORT_A_DATA  8'hc0
`define DMR_OFS_PORT_A_DIR   8'hc1
`define DMR_OFS_PORT_B_DATA  8'hc2
`define DMR_OFS_PORT_B_DIR   8'hc3
`define DMR_OFS_PORT_C_DATA  8'hc4
`define DMR_OFS_PORT_C_DIR   8'hc5
`define DMR_OFS_PORT_A_ALT   8'hca
`define DMR_OFS_PORT_B_ALT   8'hcb
`define DMR_OFS_PULLUP       8'hcc
`define DMR_OFS_TIMER0_MODE  8'hd0
`define DMR_OFS_TIMER0_DATA  8'hd1
`define DMR_OFS_TIMER1_MODE  8'hd2
`define DMR_OFS_TIMER1_CMP   8'hd3
`define DMR_OFS_TIMER1_DATA  8'hd4
`define DMR_OFS_PWM_HIGH     8'hd5
`define DMR_OFS_BUZZER       8'hde
`define DMR_OFS_INT_EN_HIGH  8'he2
`define DMR_OFS_INT_EN_LOW   8'he3
`define DMR_OFS_INT_REQ_HIGH 8'he4
`define DMR_OFS_INT_REQ_LOW  8'he5
`define DMR_OFS_EDGE_SEL     8'he6
`define DMR_OFS_ADC_MODE     8'hea
`define DMR_OFS_ADC_RESULT   8'heb
`define DMR_OFS_INTERVAL     8'hec
`define DMR_OFS_WATCHDOG     8'hed
`define DMR_OFS_POWER_FAIL   8'hef

// field positions
`define DMR_BIT_CAP0         5
`define DMR_BIT_PWME         5
`define DMR_BIT_CAP1         4

// readable-bit masks, reserved bits read as zero
`define DMR_MSK_PORT_B       8'h1f
`define DMR_MSK_PORT_C       8'h0f
`define DMR_MSK_TIMER0_MODE  8'h3f
`define DMR_MSK_INT_HIGH     8'hf0
`define DMR_MSK_INT_LOW      8'he0
`define DMR_MSK_EDGE_SEL     8'h0f
`define DMR_MSK_ADC_MODE     8'h3f
`define DMR_MSK_WATCHDOG     8'h7f
`define DMR_MSK_POWER_FAIL   8'h07

// reset values
`define DMR_RST_ZERO         8'h00
`define DMR_RST_ONES         8'hff
`define DMR_RST_ADC_MODE     8'h01
`define DMR_RST_CLK_DIV      8'h17
`define DMR_RST_WATCHDOG     8'h7f
`define DMR_RST_POWER_FAIL   8'h04

`endif

// ==== pkg/dmr_pkg.sv ====
package dmr_pkg;

  typedef enum logic [2:0] {
    DMR_AM_REGISTER,
    DMR_AM_IMMEDIATE,
    DMR_AM_DIRECT,
    DMR_AM_ABSOLUTE,
    DMR_AM_X_PLAIN,
    DMR_AM_X_AUTOINC,
    DMR_AM_LOAD_X,
    DMR_AM_LOAD_SP
  } dmr_amode_t;

  typedef enum logic [2:0] {
    DMR_RS_ACC,
    DMR_RS_X,
    DMR_RS_Y,
    DMR_RS_CARRY,
    DMR_RS_PSW
  } dmr_rsel_t;

  typedef enum logic [1:0] {
    DMR_SK_CALL,
    DMR_SK_INT,
    DMR_SK_RET,
    DMR_SK_ISR_EXIT_INSTRUCTION
  } dmr_skind_t;

  typedef struct packed {
    logic       vld;
    logic       wr;
    dmr_amode_t mode;
    dmr_rsel_t  rsel;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [7:0] wdata;
  } dmr_req_t;

  typedef struct packed {
    logic       vld;
    dmr_skind_t kind;
    logic [15:0] pc;
    logic [7:0] processor_status_word;
  } dmr_stk_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] y;
    logic       carry;
    logic [7:0] processor_status_word;
  } dmr_core_t;

  typedef struct packed {
    logic [7:0] timer0_count;
    logic [7:0] capture0_value;
    logic [7:0] timer1_count;
    logic [7:0] capture1_value;
    logic [7:0] adc_result;
    logic [7:0] interval_timer_count;
    logic [7:0] irq_set_high;
    logic [7:0] irq_set_low;
  } dmr_sts_t;

  typedef struct packed {
    logic [7:0] port_a_data;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_data;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_data;
    logic [7:0] port_c_direction;
    logic [7:0] port_a_alt_select;
    logic [7:0] port_b_alt_select;
    logic [7:0] pullup_select;
    logic [7:0] timer0_mode;
    logic [7:0] timer0_compare;
    logic [7:0] timer1_mode;
    logic [7:0] timer1_compare;
    logic [7:0] pwm_period;
    logic [7:0] pwm_duty;
    logic [7:0] pwm_high_bits;
    logic [7:0] buzzer_divider;
    logic [7:0] int_enable_high;
    logic [7:0] int_enable_low;
    logic [7:0] int_request_high;
    logic [7:0] int_request_low;
    logic [7:0] ext_int_edge_select;
    logic [7:0] adc_mode_control;
    logic [7:0] clock_divider_control;
    logic [7:0] watchdog_counter;
    logic [7:0] power_fail_control;
  } dmr_ctrl_t;

endpackage

// ==== tb/dmr_checker.sv ====
`timescale 1ns/10ps
module dmr_checker
  import dmr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire dmr_req_t    req,
  input wire dmr_stk_t    stk,
  input wire logic        ack_r,
  input wire logic [7:0]  rdata_r,
  input wire logic [15:0] eff_addr_r,
  input wire logic        busy_r,
  input wire logic        stk_done_r,
  input wire logic [7:0]  x_r,
  input wire logic [7:0]  sp_r,
  input wire dmr_ctrl_t   ctrl_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic tk;
  logic sk;
  // stack has priority, so an access in its cycle is not taken
  assign tk = req.vld && !busy_r && !stk.vld;
  assign sk = stk.vld && !busy_r;
  ////////////////////////////////////////////////////////////////
  property p_ack;
    tk |=> ack_r;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_inc;
    tk && req.mode == DMR_AM_X_AUTOINC |=> x_r == $past(x_r) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("x not bumped");
  property p_xad;
    tk && req.mode == DMR_AM_X_PLAIN |=> eff_addr_r == {8'h00, $past(x_r)};
  endproperty
  a_xad: assert property (p_xad) else $error("x address");
  property p_abs;
    tk && req.mode == DMR_AM_ABSOLUTE |=> eff_addr_r == {$past(req.op2), $past(req.op1)};
  endproperty
  a_abs: assert property (p_abs) else $error("abs address");
  property p_imm;
    tk && req.mode == DMR_AM_IMMEDIATE && !req.wr |=> rdata_r == $past(req.op1);
  endproperty
  a_imm: assert property (p_imm) else $error("imm data");
  property p_hole;
    tk && !req.wr && req.mode == DMR_AM_DIRECT && req.op1[7:6] == 2'b10 |=> rdata_r == 8'h00;
  endproperty
  a_hole: assert property (p_hole) else $error("hole data");
  property p_ckd;
    tk && req.wr && req.mode == DMR_AM_DIRECT && req.op1 == 8'hec
      |=> ctrl_r.clock_divider_control == $past(req.wdata);
  endproperty
  a_ckd: assert property (p_ckd) else $error("divider");
  property p_call;
    sk && stk.kind == DMR_SK_CALL |-> ##3 stk_done_r && sp_r == $past(sp_r, 3) - 8'h02;
  endproperty
  a_call: assert property (p_call) else $error("call push");
  property p_isr_exit_instruction;
    sk && stk.kind == DMR_SK_ISR_EXIT_INSTRUCTION |-> ##4 stk_done_r && sp_r == $past(sp_r, 4) + 8'h03;
  endproperty
  a_isr_exit_instruction: assert property (p_isr_exit_instruction) else $error("isr_exit_instruction pop");
  property p_busy;
    sk |=> busy_r [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("busy");
  c_call: cover property (sk && stk.kind == DMR_SK_CALL);
  c_isr_exit_instruction: cover property (sk && stk.kind == DMR_SK_ISR_EXIT_INSTRUCTION);
  c_inc: cover property (tk && req.mode == DMR_AM_X_AUTOINC);
endmodule

bind dmr_data_memory dmr_checker u_chk (.clk, .rstn, .req, .stk, .ack_r, .rdata_r,
  .eff_addr_r, .busy_r, .stk_done_r, .x_r, .sp_r, .ctrl_r);

// ==== tb/dmr_core_model.sv ====
`timescale 1ns/10ps
module dmr_core_model
  import dmr_pkg::*;
(
  input  wire logic clk,
  input  wire logic ack_r,
  input  wire logic stk_done_r,
  output dmr_req_t  req,
  output dmr_stk_t  stk
);
  initial begin
    req = '0;
    stk = '0;
  end
  // one byte per store; register mode takes its select from b
  task automatic acc(input dmr_amode_t m, input logic w, input logic [7:0] a,
                     input logic [7:0] b, input logic [7:0] d, output logic ok);
    @(posedge clk);
    req <= '{1'b1, w, m, dmr_rsel_t'(b[2:0]), a, b, d};
    @(posedge clk);
    req.vld <= 1'b0;
    #1;
    ok = ack_r;
  endtask
  task automatic push(input dmr_skind_t k, input logic [15:0] pc,
                      input logic [7:0] f, output int n);
    @(posedge clk);
    stk <= '{1'b1, k, pc, f};
    @(posedge clk);
    stk.vld <= 1'b0;
    #1;
    n = 1;
    while (stk_done_r !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
endmodule

// ==== tb/dmr_data_memory_register_map_bench.sv ====
`timescale 1ns/10ps
module dmr_data_memory_register_map_bench
  import dmr_pkg::*;
;
  logic        clk;
  logic        rstn;
  dmr_req_t    req;
  dmr_stk_t    stk;
  dmr_core_t   core;
  dmr_sts_t    sts;
  logic        ack_r;
  logic        busy_r;
  logic        stk_done_r;
  logic [7:0]  rdata_r;
  logic [7:0]  x_r;
  logic [7:0]  sp_r;
  logic [7:0]  psw_restore_r;
  logic [15:0] eff_addr_r;
  logic [15:0] pc_restore_r;
  dmr_ctrl_t   ctrl_r;
  int          err_count;
  int          comparisons;
  int          n;
  logic        ok;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  dmr_data_memory dut (.clk(clk), .rstn(rstn), .req(req), .stk(stk), .core(core),
    .sts(sts), .pin_a(8'h96), .pin_b(8'h00), .pin_c(8'h00), .ack_r(ack_r),
    .rdata_r(rdata_r), .eff_addr_r(eff_addr_r), .busy_r(busy_r), .stk_done_r(stk_done_r),
    .pc_restore_r(pc_restore_r), .psw_restore_r(psw_restore_r), .x_r(x_r), .sp_r(sp_r),
    .ctrl_r(ctrl_r));
  dmr_core_model core_m (.clk(clk), .ack_r(ack_r), .stk_done_r(stk_done_r), .req(req),
    .stk(stk));
  ////////////////////////////////////////////////////////////////
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    chk16({8'h00, got}, {8'h00, exp});
  endtask
  task rd(input dmr_amode_t m, input logic [7:0] a, input logic [7:0] b,
          input logic [7:0] e);
    core_m.acc(m, 1'b0, a, b, 8'h00, ok);
    chk16({7'h00, ok, rdata_r}, {8'h01, e});
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    core_m.acc(DMR_AM_DIRECT, 1'b1, a, 8'h00, d, ok);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    chk8(ctrl_r.timer0_compare, 8'hff);
    chk8(ctrl_r.pwm_period, 8'hff);
    chk8(ctrl_r.buzzer_divider, 8'hff);
    chk8(ctrl_r.adc_mode_control, 8'h01);
    chk8(ctrl_r.clock_divider_control, 8'h17);
    chk8(ctrl_r.watchdog_counter, 8'h7f);
    chk8(ctrl_r.power_fail_control, 8'h04);
    chk8(ctrl_r.port_b_direction, 8'h00);
    $display("reset test done");
  endtask
  task t_ram;
    wr(8'h35, 8'ha5);
    rd(DMR_AM_DIRECT, 8'h35, 8'h00, 8'ha5);
    wr(8'h7f, 8'h3c);
    rd(DMR_AM_DIRECT, 8'h7f, 8'h00, 8'h3c);
    wr(8'hbf, 8'h77);
    rd(DMR_AM_DIRECT, 8'hbf, 8'h00, 8'h00);
    rd(DMR_AM_DIRECT, 8'h80, 8'h00, 8'h00);
    wr(8'hc1, 8'h55);
    chk8(ctrl_r.port_a_direction, 8'h55);
    rd(DMR_AM_DIRECT, 8'hc0, 8'h00, 8'h96);
    $display("ram test done");
  endtask
  task t_modes;
    core_m.acc(DMR_AM_LOAD_X, 1'b1, 8'h00, 8'h00, 8'h35, ok);
    rd(DMR_AM_X_PLAIN, 8'h00, 8'h00, 8'ha5);
    chk16(eff_addr_r, 16'h0035);
    core_m.acc(DMR_AM_X_AUTOINC, 1'b1, 8'h00, 8'h00, 8'h66, ok);
    chk8(x_r, 8'h36);
    rd(DMR_AM_ABSOLUTE, 8'h35, 8'h00, 8'h66);
    rd(DMR_AM_ABSOLUTE, 8'h35, 8'h01, 8'h00);
    chk16(eff_addr_r, 16'h0135);
    rd(DMR_AM_IMMEDIATE, 8'h9e, 8'h00, 8'h9e);
    rd(DMR_AM_REGISTER, 8'h00, 8'h00, 8'hc3);
    rd(DMR_AM_REGISTER, 8'h00, 8'h01, 8'h36);
    rd(DMR_AM_REGISTER, 8'h00, 8'h02, 8'h5a);
    rd(DMR_AM_REGISTER, 8'h00, 8'h03, 8'h01);
    rd(DMR_AM_REGISTER, 8'h00, 8'h04, 8'h81);
    $display("mode test done");
  endtask
  task t_shared;
    wr(8'hec, 8'h09);
    chk8(ctrl_r.clock_divider_control, 8'h09);
    rd(DMR_AM_DIRECT, 8'hec, 8'h00, 8'h60);
    wr(8'hd1, 8'h33);
    chk8(ctrl_r.timer0_compare, 8'h33);
    rd(DMR_AM_DIRECT, 8'hd1, 8'h00, 8'h10);
    wr(8'hd0, 8'h20);
    rd(DMR_AM_DIRECT, 8'hd1, 8'h00, 8'h20);
    wr(8'hd3, 8'h5a);
    chk8(ctrl_r.timer1_compare, 8'h5a);
    wr(8'hd2, 8'h20);
    wr(8'hd3, 8'ha5);
    chk8(ctrl_r.pwm_period, 8'ha5);
    wr(8'hd4, 8'h4b);
    rd(DMR_AM_DIRECT, 8'hd4, 8'h00, 8'h4b);
    wr(8'hd2, 8'h10);
    rd(DMR_AM_DIRECT, 8'hd4, 8'h00, 8'h40);
    wr(8'hd2, 8'h00);
    rd(DMR_AM_DIRECT, 8'hd4, 8'h00, 8'h30);
    wr(8'hd4, 8'h99);
    chk8(ctrl_r.pwm_duty, 8'h4b);
    $display("shared address test done");
  endtask
  task t_stack;
    core_m.acc(DMR_AM_LOAD_SP, 1'b1, 8'h00, 8'h00, 8'h7f, ok);
    core_m.push(DMR_SK_CALL, 16'h1234, 8'h00, n);
    chk8({n[7:0]}, 8'h03);
    chk8(sp_r, 8'h7d);
    rd(DMR_AM_DIRECT, 8'h7f, 8'h00, 8'h12);
    rd(DMR_AM_DIRECT, 8'h7e, 8'h00, 8'h34);
    core_m.push(DMR_SK_RET, 16'h0000, 8'h00, n);
    chk16(pc_restore_r, 16'h1234);
    chk8(sp_r, 8'h7f);
    core_m.push(DMR_SK_INT, 16'habcd, 8'h5c, n);
    chk8({n[7:0]}, 8'h04);
    rd(DMR_AM_DIRECT, 8'h7d, 8'h00, 8'h5c);
    core_m.push(DMR_SK_ISR_EXIT_INSTRUCTION, 16'h0000, 8'h00, n);
    chk16(pc_restore_r, 16'habcd);
    chk8(psw_restore_r, 8'h5c);
    $display("stack test done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    err_count = 0;
    comparisons = 0;
    core = '{8'hc3, 8'h5a, 1'b1, 8'h81};
    sts = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h00, 8'h00};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_ram();
    t_modes();
    t_shared();
    t_stack();
    finish_test();
  end
  // the sequence needs well under 400 cycles; 4000 leaves room without hiding a hang
  initial begin
    #20000;
    err_count++;
    finish_test();
  end
endmodule
